// ===== inc/dms_pkg.sv
// Shared constants and types for the delta modulator bit sampler
package dms_pkg;

  // ****************************************
  // Widths and sizes
  // ****************************************
  localparam int DMS_ERR_W      = 12;
  localparam int DMS_BIP_W      = 8;
  localparam int DMS_SYNC_N     = 3;
  localparam int DMS_FIFO_DEPTH = 32;
  localparam int DMS_FIFO_W     = 2;

  // ****************************************
  // Levels and reset values
  // ****************************************
  localparam logic signed [DMS_BIP_W-1:0] DMS_BIP_AMP = 8'h40;
  localparam logic [1:0]                  DMS_CNT_RST  = 2'h0;
  localparam logic [2:0]                  DMS_HIST_RST = 3'h0;
  localparam logic [1:0]                  DMS_HCNT_RST = 2'h0;
  localparam logic [1:0]                  DMS_HCNT_FULL = 2'h3;
  localparam logic                        DMS_BIT_RST  = 1'b0;
  localparam logic                        DMS_OVL_RST  = 1'b0;

  // ****************************************
  // Rate select and divider terminal counts
  // ****************************************
  typedef enum logic [1:0] {
    DMS_RATE_DIV1  = 2'b00,
    DMS_RATE_DIV2  = 2'b01,
    DMS_RATE_DIV4  = 2'b10,
    DMS_RATE_SPARE = 2'b11
  } dms_rate_t;

  localparam logic [1:0] DMS_DIV1_LAST = 2'h0;
  localparam logic [1:0] DMS_DIV2_LAST = 2'h1;
  localparam logic [1:0] DMS_DIV4_LAST = 2'h3;

endpackage

// ===== src/dms_fifo.sv
// Parameterised FIFO with registered output stage and registered ready
`timescale 1ns/100ps
`default_nettype none
module dms_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_ptr_q;
  logic [PW-1:0]    rd_ptr_q;
  logic [PW:0]      count_q;
  logic [PW:0]      count_d;
  logic             in_ready_q;
  logic             out_valid_q;
  logic [WIDTH-1:0] out_data_q;

  wire push     = in_valid && in_ready_q;
  wire has_data = count_q != '0;
  wire pop      = has_data && (!out_valid_q || out_ready);

  assign count_d   = count_q + (PW+1)'(push) - (PW+1)'(pop);
  assign in_ready  = in_ready_q;
  assign out_valid = out_valid_q;
  assign out_data  = out_data_q;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_q    <= '0;
      rd_ptr_q    <= '0;
      count_q     <= '0;
      in_ready_q  <= 1'b0;
      out_valid_q <= 1'b0;
      out_data_q  <= '0;
    end else begin
      wr_ptr_q   <= push ? wr_ptr_q + PW'(1) : wr_ptr_q;
      rd_ptr_q   <= pop ? rd_ptr_q + PW'(1) : rd_ptr_q;
      count_q    <= count_d;
      in_ready_q <= count_d < (PW+1)'(DEPTH);
      if (pop) begin
        out_valid_q <= 1'b1;
        out_data_q  <= mem_q[rd_ptr_q];
      end else if (out_ready) begin
        out_valid_q <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ===== src/dms_sampler.sv
// Quantiser, divided sampler, bipolar output and slope overload detector
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Quantised bit is one only when the error word is above zero.
// - Sample once per divided period and hold the bit until the next.
// - Divide the incoming sample clock by one, two or four per rate select.
// - Each sample appears as a logic bit and as plus or minus amplitude.
// - Overload flag sets on the third of three equal consecutive bits.
// - Overload flag is inactive whenever the last three bits differ.
// - Overload flag is always driven, in every configuration.
module dms_sampler
  import dms_pkg::*;
#(
  parameter int                           ERR_W      = DMS_ERR_W,
  parameter int                           BIP_W      = DMS_BIP_W,
  parameter logic signed [DMS_BIP_W-1:0]  BIP_AMP    = DMS_BIP_AMP,
  parameter int                           FIFO_DEPTH = DMS_FIFO_DEPTH
) (
  input  wire logic                    CLOCK_IN,
  input  wire logic                    RST_IN,
  input  wire logic signed [ERR_W-1:0] ERROR_IN,
  input  wire logic                    SAMPLE_CLK_IN,
  input  wire logic [1:0]              RATE_SEL_IN,
  input  wire logic                    STREAM_READY_IN,
  output logic                         BIT_OUT,
  output logic signed [BIP_W-1:0]      BIPOLAR_OUT,
  output logic                         OVERLOAD_OUT,
  output logic                         STREAM_VALID_OUT,
  output logic [DMS_FIFO_W-1:0]        STREAM_DATA_OUT,
  output logic                         STREAM_ROOM_OUT
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [2:0] pin_raw;
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] sync3_q;
  logic [2:0] lvl_q;

  assign pin_raw = {RATE_SEL_IN, SAMPLE_CLK_IN};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge CLOCK_IN) begin
        if (RST_IN) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
          sync3_q[gi] <= 1'b0;
          lvl_q[gi]   <= 1'b0;
        end else begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
          sync3_q[gi] <= sync2_q[gi];
          if (sync2_q[gi] == sync3_q[gi]) begin
            lvl_q[gi] <= sync3_q[gi];
          end
        end
      end
    end
  endgenerate

  // Agreed rising edge of the sample clock
  wire       sclk_rise = sync2_q[0] && sync3_q[0] && !lvl_q[0];
  wire [1:0] rate_sel  = lvl_q[2:1];

  // ****************************************
  // Rate divider
  // ****************************************
  function automatic logic [1:0] div_last(input logic [1:0] rate);
    dms_rate_t r;
    r = dms_rate_t'(rate);
    unique case (r)
      DMS_RATE_DIV1:  div_last = DMS_DIV1_LAST;
      DMS_RATE_DIV2:  div_last = DMS_DIV2_LAST;
      DMS_RATE_DIV4:  div_last = DMS_DIV4_LAST;
      DMS_RATE_SPARE: div_last = DMS_DIV4_LAST;
    endcase
  endfunction

  logic [1:0] cnt_q;
  logic [1:0] rate_q;
  wire  [1:0] last_cnt = div_last(rate_sel);
  wire        rate_chg = rate_sel != rate_q;
  wire        at_last  = cnt_q == last_cnt;
  wire        tick     = sclk_rise && at_last;

  // Restart the count when the agreed rate changes, so it never runs past the terminal count
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      cnt_q  <= DMS_CNT_RST;
      rate_q <= DMS_RATE_DIV1;
    end else begin
      rate_q <= rate_sel;
      if (rate_chg || (sclk_rise && at_last)) begin
        cnt_q <= DMS_CNT_RST;
      end else if (sclk_rise) begin
        cnt_q <= cnt_q + 2'h1;
      end
    end
  end

  // ****************************************
  // Quantiser, sampler and overload detector
  // ****************************************
  logic                    bit_q;
  logic signed [BIP_W-1:0] bip_q;
  logic                    ovl_q;
  logic [2:0]              hist_q;
  logic [1:0]              hcnt_q;

  wire       err_pos = ERROR_IN > $signed({ERR_W{1'b0}});
  wire [2:0] hist_d  = {hist_q[1:0], err_pos};
  wire       same3   = (hist_d == 3'h7) || (hist_d == 3'h0);
  wire       full_d  = hcnt_q >= 2'h2;

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      bit_q  <= DMS_BIT_RST;
      bip_q  <= -BIP_AMP;
      ovl_q  <= DMS_OVL_RST;
      hist_q <= DMS_HIST_RST;
      hcnt_q <= DMS_HCNT_RST;
    end else if (tick) begin
      bit_q  <= err_pos;
      bip_q  <= err_pos ? BIP_AMP : -BIP_AMP;
      ovl_q  <= same3 && full_d;
      hist_q <= hist_d;
      hcnt_q <= full_d ? DMS_HCNT_FULL : hcnt_q + 2'h1;
    end
  end

  assign BIT_OUT      = bit_q;
  assign BIPOLAR_OUT  = bip_q;
  assign OVERLOAD_OUT = ovl_q;

  // ****************************************
  // Sample stream buffer
  // ****************************************
  logic tick_q;

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= tick;
    end
  end

  // A sample offered while the buffer is full is not queued
  dms_fifo #(
    .WIDTH (DMS_FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLOCK_IN),
    .rst       (RST_IN),
    .in_valid  (tick_q),
    .in_ready  (STREAM_ROOM_OUT),
    .in_data   ({ovl_q, bit_q}),
    .out_valid (STREAM_VALID_OUT),
    .out_ready (STREAM_READY_IN),
    .out_data  (STREAM_DATA_OUT)
  );

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_sample;
    tick ##1 1'b1;
  endsequence

  property p_quant;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      tick |=> (bit_q == ($past(ERROR_IN) > 0));
  endproperty
  a_quant: assert property (p_quant) else $error("quantised bit wrong sense");

  property p_hold;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      (!tick && !$past(RST_IN)) |=> ($stable(bit_q) && $stable(ovl_q));
  endproperty
  a_hold: assert property (p_hold) else $error("outputs changed between samples");

  property p_div;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      tick |-> (sclk_rise && cnt_q == div_last(rate_sel));
  endproperty
  a_div: assert property (p_div) else $error("sample not at divider terminal");

  property p_div_range;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      (rate_sel == DMS_RATE_DIV1) |-> (cnt_q == DMS_CNT_RST || $past(rate_sel) != rate_sel);
  endproperty
  a_div_range: assert property (p_div_range) else $error("divider counted at rate one");

  property p_forms;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      bip_q == (bit_q ? BIP_AMP : -BIP_AMP);
  endproperty
  a_forms: assert property (p_forms) else $error("bipolar form disagrees with bit");

  property p_ovl_set;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      (tick && same3 && full_d) |=> ovl_q;
  endproperty
  a_ovl_set: assert property (p_ovl_set) else $error("overload missed on third bit");

  property p_ovl_clr;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      (tick && !same3) |=> !ovl_q;
  endproperty
  a_ovl_clr: assert property (p_ovl_clr) else $error("overload with differing bits");

  property p_ovl_hist;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      ovl_q |-> (hcnt_q == DMS_HCNT_FULL && (hist_q == 3'h7 || hist_q == 3'h0) && OVERLOAD_OUT);
  endproperty
  a_ovl_hist: assert property (p_ovl_hist) else $error("overload flag without history");

  property p_stream;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      s_sample |-> (tick_q && $past(tick));
  endproperty
  a_stream: assert property (p_stream) else $error("sample not offered to buffer");

  property p_reset;
    @(posedge CLOCK_IN)
      RST_IN |=> (cnt_q == DMS_CNT_RST && hist_q == DMS_HIST_RST && !ovl_q && !bit_q);
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");

endmodule
`default_nettype wire

// ===== verification/dms_loop_model.sv
// Feedback loop model: adder and stepwise integrator
`timescale 1ns/100ps
`default_nettype none
module dms_loop_model
  import dms_pkg::*;
(
  input  wire logic                        clk_in,
  input  wire logic                        rst_in,
  input  wire logic                        step_in,
  input  wire logic signed [DMS_BIP_W-1:0] bip_in,
  input  wire logic signed [DMS_ERR_W-1:0] msg_in,
  output logic signed [DMS_ERR_W-1:0]      err_out
);
  logic signed [DMS_ERR_W+1:0] integ_q;
  logic signed [DMS_ERR_W+1:0] diff;
  logic                        prev_q;
  // Integrate once per sample clock fall, so error is still while the pin is high
  always_ff @(posedge clk_in) begin
    prev_q <= step_in;
    if (rst_in) begin
      integ_q <= '0;
    end else if (prev_q && !step_in) begin
      integ_q <= integ_q + bip_in;
    end
  end
  assign diff    = msg_in - integ_q;
  assign err_out = (diff > 14'sh07FF) ? 12'sh7FF : (diff < -14'sh0800) ? 12'sh800 : diff[DMS_ERR_W-1:0];
endmodule
`default_nettype wire

// ===== verification/tb_dms_sampler.sv
// Self-checking bench for the delta modulator bit sampler
`timescale 1ns/100ps
`default_nettype none
module tb_dms_sampler
  import dms_pkg::*;
;
  logic clk, rst, smp, rdy, rnd, loop, bo, oo, vo, ro, cb, co;
  logic [1:0] rate;
  logic [2:0] hist;
  logic signed [DMS_ERR_W-1:0] etb, elp, ein, msg;
  logic signed [DMS_BIP_W-1:0] bp;
  logic [DMS_FIFO_W-1:0] dq, eq[$];
  int err_count, n_compared, seed, np, nt, dv, i, j;
  logic signed [DMS_ERR_W-1:0] corner[14] = '{12'sh000, 12'sh001, -12'sh001, 12'sh7FF, 12'sh800, 12'sh001,
    12'sh005, 12'sh100, 12'sh002, 12'sh000, -12'sh010, 12'sh800, 12'sh001, 12'sh000};
  assign ein = loop ? elp : etb;
  dms_sampler i_dms_sampler (.CLOCK_IN(clk), .RST_IN(rst), .ERROR_IN(ein), .SAMPLE_CLK_IN(smp),
    .RATE_SEL_IN(rate), .STREAM_READY_IN(rdy), .BIT_OUT(bo), .BIPOLAR_OUT(bp), .OVERLOAD_OUT(oo),
    .STREAM_VALID_OUT(vo), .STREAM_DATA_OUT(dq), .STREAM_ROOM_OUT(ro));
  dms_loop_model i_dms_loop_model (.clk_in(clk), .rst_in(rst), .step_in(smp), .bip_in(bp),
    .msg_in(msg), .err_out(elp));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] ex);
    n_compared++;
    if (seen !== ex) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  task automatic wrap_up();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic logic signed [DMS_BIP_W-1:0] bip_of(input logic b);
    return b ? DMS_BIP_AMP : -DMS_BIP_AMP;
  endfunction
  task automatic step(input int n);
    repeat (n) begin
      @(posedge clk);
      if (rnd) rdy <= 1'($random(seed));
    end
  endtask
  // Stream sink: every accepted word must be the oldest expected one
  always @(posedge clk) begin
    if (!rst && vo && rdy) begin
      if (eq.size() == 0) check("stream extra", 1, 0);
      else check("STREAM_DATA_OUT", dq, eq.pop_front());
    end
  end
  task automatic do_reset(input logic [1:0] r);
    rnd = 1'b0;
    if (!rst) begin
      step(1);
      rdy <= 1'b1;
      step(39);
      rst <= 1'b1;
    end
    rate <= r;
    step(11);
    #1;
    check("BIT_OUT rst", bo, DMS_BIT_RST);
    check("BIPOLAR_OUT rst", bp, -DMS_BIP_AMP);
    check("OVERLOAD_OUT rst", oo, DMS_OVL_RST);
    check("STREAM_VALID_OUT rst", vo, 0);
    step(1);
    rst <= 1'b0;
    eq.delete();
    {np, nt, hist, cb, co} = '0;
    dv = (r == 2'b00) ? 1 : (r == 2'b01) ? 2 : 4;
    step(10);
    check("STREAM_ROOM_OUT", ro, 1);
  endtask
  task automatic pulse(input logic signed [DMS_ERR_W-1:0] e);
    step(1);
    etb <= e;
    step(1);
    smp <= 1'b1;
    step(1);
    #1;
    np++;
    if (np % dv == 0) begin
      nt++;
      cb = ein > 0;
      hist = {hist[1:0], cb};
      co = nt >= 3 && (hist == 3'h7 || hist == 3'h0);
      if (eq.size() < DMS_FIFO_DEPTH + 1) eq.push_back({co, cb});
    end
    step(3);
    smp <= 1'b0;
    step(4);
    #1;
    check("BIT_OUT", bo, cb);
    check("BIPOLAR_OUT", bp, bip_of(cb));
    check("OVERLOAD_OUT", oo, co);
  endtask
  initial begin
    {rst, smp, rdy, rnd, loop, rate, etb, msg, err_count, n_compared} = '0;
    rst = 1'b1;
    rdy = 1'b1;
    seed = 32'h853E;
    do_reset(2'b00);
    foreach (corner[k]) begin
      pulse(corner[k]);
    end
    $display("Test corner values done");
    for (i = 0; i < 4; i++) begin
      do_reset(2'(i));
      rnd = 1'b1;
      for (j = 0; j < 24; j++) pulse(12'($random(seed)));
      $display("Test rate select %0d done", i);
    end
    do_reset(2'b01);
    loop <= 1'b1;
    rnd = 1'b1;
    msg <= 12'h180;
    for (j = 0; j < 40; j++) pulse(12'h000);
    $display("Test feedback loop done");
    do_reset(2'b00);
    loop <= 1'b0;
    rdy <= 1'b0;
    for (j = 0; j < 40; j++) pulse(12'($random(seed)));
    check("STREAM_ROOM_OUT full", ro, 0);
    step(1);
    rdy <= 1'b1;
    step(40);
    check("stream words left", eq.size(), 0);
    $display("Test buffer fill and drain done");
    wrap_up();
  end
  initial begin
    #2000000;
    err_count++;
    $display("Run cut short by watchdog");
    wrap_up();
  end
endmodule
`default_nettype wire
